// ### hdl/pmar_pkg.sv
// Package: register map, reset values and frame layout of the power mode and alarm slice
package pmar_pkg;

    // ----------------------------------------------------------------
    // Register offsets on the serial register port
    // ----------------------------------------------------------------
    localparam logic [14:0] PMAR_ADDR_MODE_B = 15'h029A;
    localparam logic [14:0] PMAR_ADDR_MODE_C = 15'h029B;
    localparam logic [14:0] PMAR_ADDR_MODE_D = 15'h029C;
    localparam logic [14:0] PMAR_ADDR_SUMMARY = 15'h02C0;
    localparam logic [14:0] PMAR_ADDR_FLAGS = 15'h02C1;
    localparam logic [14:0] PMAR_ADDR_MASK = 15'h02C2;

    // ----------------------------------------------------------------
    // Operating point encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PMAR_CODE_B_LOW = 8'h06;
    localparam logic [7:0] PMAR_CODE_B_HIGH = 8'h0F;
    localparam logic [7:0] PMAR_CODE_C_LOW = 8'h00;
    localparam logic [7:0] PMAR_CODE_C_HIGH = 8'h04;
    localparam logic [7:0] PMAR_CODE_D_LOW = 8'h14;
    localparam logic [7:0] PMAR_CODE_D_HIGH = 8'h1B;
    localparam logic [7:0] PMAR_RST_MODE_B = PMAR_CODE_B_HIGH;
    localparam logic [7:0] PMAR_RST_MODE_C = PMAR_CODE_C_HIGH;
    localparam logic [7:0] PMAR_RST_MODE_D = PMAR_CODE_D_HIGH;

    // ----------------------------------------------------------------
    // Alarm flag positions and reset values
    // ----------------------------------------------------------------
    localparam int PMAR_BIT_CLKDIV = 0;
    localparam int PMAR_BIT_RSVD = 1;
    localparam int PMAR_BIT_REALIGN = 2;
    localparam int PMAR_BIT_LINK = 3;
    localparam int PMAR_BIT_PLL = 4;
    localparam int PMAR_BIT_FIFO = 5;
    localparam int PMAR_ALARM_BITS = 6;
    localparam logic [5:0] PMAR_RST_FLAGS = 6'h3F;
    localparam logic [5:0] PMAR_RST_MASK = 6'h3F;

    // ----------------------------------------------------------------
    // Serial frame layout: read bit, 15-bit address, 8-bit data
    // ----------------------------------------------------------------
    localparam logic [4:0] PMAR_HDR_BITS = 5'h10;
    localparam logic [4:0] PMAR_FRAME_BITS = 5'h18;

endpackage

// ### hdl/pmar_serial_port.sv
// Serial register port: frame decode, write strobe and read data shifter
`timescale 1ns/1ps
module pmar_serial_port
    import pmar_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic reset, // Async reset, high
    input wire logic port_sclk, // Serial clock, sampled
    input wire logic port_sel_n, // Frame select, low active
    input wire logic port_sdi, // Serial data in
    output logic port_sdo, // Serial data out
    output logic port_sdo_oe, // High while driving data out
    output logic [14:0] reg_addr, // Address of current frame
    output logic reg_wr, // One-cycle write strobe
    output logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata // Read data for reg_addr
);

    logic sclk_q, sclk_d;
    logic [4:0] cnt_q, cnt_d;
    logic [22:0] shift_q, shift_d;
    logic [15:0] hdr_q, hdr_d;
    logic [7:0] out_q, out_d;
    logic oe_q, oe_d;
    logic wr_q, wr_d;
    logic [7:0] wdata_q, wdata_d;
    logic rise, fall;

    // ----------------------------------------------------------------
    // Frame engine
    // ----------------------------------------------------------------
    // Edges come from the sampled serial clock, so sclk must stay well below clk/4
    always_comb begin
        rise = port_sclk & ~sclk_q;
        fall = ~port_sclk & sclk_q;
        sclk_d = port_sclk;
        cnt_d = cnt_q;
        shift_d = shift_q;
        hdr_d = hdr_q;
        out_d = out_q;
        oe_d = oe_q;
        wr_d = 1'b0;
        wdata_d = wdata_q;
        if (port_sel_n) begin
            cnt_d = 5'h00;
            oe_d = 1'b0;
        end else begin
            if (rise && cnt_q < PMAR_FRAME_BITS) begin
                shift_d = {shift_q[21:0], port_sdi};
                cnt_d = cnt_q + 5'h01;
                if (cnt_q == PMAR_HDR_BITS - 5'h01) begin
                    hdr_d = {shift_q[14:0], port_sdi};
                end
                if (cnt_q == PMAR_FRAME_BITS - 5'h01 && !hdr_q[15]) begin
                    wr_d = 1'b1;
                    wdata_d = {shift_q[6:0], port_sdi};
                end
            end
            // Read data is launched on falling edges so the master samples it on rising ones
            if (fall && hdr_q[15] && cnt_q == PMAR_HDR_BITS) begin
                out_d = reg_rdata;
                oe_d = 1'b1;
            end else if (fall && oe_q) begin
                out_d = {out_q[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sclk_q <= 1'b0;
            cnt_q <= 5'h00;
            shift_q <= 23'h0;
            hdr_q <= 16'h0000;
            out_q <= 8'h00;
            oe_q <= 1'b0;
            wr_q <= 1'b0;
            wdata_q <= 8'h00;
        end else begin
            sclk_q <= sclk_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            hdr_q <= hdr_d;
            out_q <= out_d;
            oe_q <= oe_d;
            wr_q <= wr_d;
            wdata_q <= wdata_d;
        end
    end

    assign port_sdo = out_q[7];
    assign port_sdo_oe = oe_q;
    assign reg_addr = hdr_q[14:0];
    assign reg_wr = wr_q;
    assign reg_wdata = wdata_q;

endmodule

// ### hdl/pmar_regs.sv
// Power mode selection registers and alarm aggregation, top level
`timescale 1ns/1ps
// How it works
// - Mode register b holds 0x06 low power, 0x0F high performance; resets 0x0F.
// - Mode register c holds 0x00 low power, 0x04 high performance; resets 0x04.
// - Mode register d holds 0x14 low power, 0x1B high performance; resets 0x1B.
// - Summary bit 0 reads 1 when any flag is set and unmasked.
// - A select input routes the summary onto the status output pin.
// - Flags reset to 0x3F and clear only by writing ones.
// - Flag 5 sets on any lane FIFO overflow or underflow; write 1 clears.
// - Flag 4 sets while the serializer PLL is unlocked; write 1 clears.
// - Flag 3: link enabled but not transferring; 64b/66b: start-up or realignment.
// - Flag 2 sets whenever the reference input realigns the internal clocks.
// - Mask register mirrors flag positions and resets to 0x3F.
module pmar_regs
    import pmar_pkg::*;
(
    input wire logic clk, // 100 MHz system clock
    input wire logic reset, // Async reset, high
    input wire logic port_sclk, // Serial port clock
    input wire logic port_sel_n, // Serial port select, low active
    input wire logic port_sdi, // Serial port data in
    output logic port_sdo, // Serial port data out
    output logic port_sdo_oe, // Data out enable
    input wire logic serial_link_enable, // Link enabled
    input wire logic link_data_state, // Link in data transfer state
    input wire logic link_mode_64b66b, // Link runs 64b/66b coding
    input wire logic link_realign, // Pulse: FIFO or serializer realignment
    input wire logic lane_fifo_error, // Any active lane FIFO over/underflow
    input wire logic serializer_pll_locked, // Serializer PLL lock
    input wire logic sysref_realign, // Pulse: reference realigned clocks
    input wire logic clock_divider_mismatch, // Channel clock dividers disagree
    input wire logic status_pin_select_alarm, // Route summary to status pin
    input wire logic calibration_status, // Normal status pin source
    output logic status_output_pin, // Status output pin
    output logic [7:0] operating_point_code_b, // Mode b code
    output logic [7:0] operating_point_code_c, // Mode c code
    output logic [7:0] operating_point_code_d // Mode d code
);

    logic [14:0] reg_addr;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] mode_b_q, mode_b_d, mode_c_q, mode_c_d, mode_d_q, mode_d_d;
    logic [5:0] flags_q, flags_d, mask_q, mask_d, flag_set;
    logic link_en_q, link_en_d;
    logic pin_q, pin_d;
    logic summary_w;

    // Write strobe aimed at one register
    function automatic logic hit(input logic wr, input logic [14:0] a, input logic [14:0] r);
        return wr && (a == r);
    endfunction

    // ----------------------------------------------------------------
    // Serial register port
    // ----------------------------------------------------------------
    pmar_serial_port u_port (
        .clk(clk),
        .reset(reset),
        .port_sclk(port_sclk),
        .port_sel_n(port_sel_n),
        .port_sdi(port_sdi),
        .port_sdo(port_sdo),
        .port_sdo_oe(port_sdo_oe),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata)
    );

    // ----------------------------------------------------------------
    // Operating point registers
    // ----------------------------------------------------------------
    // Any byte is stored; keeping to the legal codes is left to software
    always_comb begin
        mode_b_d = hit(reg_wr, reg_addr, PMAR_ADDR_MODE_B) ? reg_wdata : mode_b_q;
        mode_c_d = hit(reg_wr, reg_addr, PMAR_ADDR_MODE_C) ? reg_wdata : mode_c_q;
        mode_d_d = hit(reg_wr, reg_addr, PMAR_ADDR_MODE_D) ? reg_wdata : mode_d_q;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_b_q <= PMAR_RST_MODE_B;
            mode_c_q <= PMAR_RST_MODE_C;
            mode_d_q <= PMAR_RST_MODE_D;
        end else begin
            mode_b_q <= mode_b_d;
            mode_c_q <= mode_c_d;
            mode_d_q <= mode_d_d;
        end
    end

    assign operating_point_code_b = mode_b_q;
    assign operating_point_code_c = mode_c_q;
    assign operating_point_code_d = mode_d_q;

    // ----------------------------------------------------------------
    // Alarm sources
    // ----------------------------------------------------------------
    // Start-up of a 64b/66b link is the rising edge of the link enable
    always_comb begin
        link_en_d = serial_link_enable;
        flag_set = '0;
        flag_set[PMAR_BIT_CLKDIV] = clock_divider_mismatch;
        flag_set[PMAR_BIT_REALIGN] = sysref_realign;
        flag_set[PMAR_BIT_PLL] = ~serializer_pll_locked;
        flag_set[PMAR_BIT_FIFO] = lane_fifo_error;
        if (link_mode_64b66b) begin
            flag_set[PMAR_BIT_LINK] = (serial_link_enable & ~link_en_q) | link_realign;
        end else begin
            flag_set[PMAR_BIT_LINK] = serial_link_enable & ~link_data_state;
        end
    end

    // ----------------------------------------------------------------
    // Flags, mask and summary
    // ----------------------------------------------------------------
    // Set beats clear so an event in the clearing cycle is never lost
    always_comb begin
        flags_d = flags_q;
        mask_d = mask_q;
        if (hit(reg_wr, reg_addr, PMAR_ADDR_FLAGS)) begin
            flags_d = flags_q & ~reg_wdata[5:0];
        end
        flags_d = flags_d | flag_set;
        if (hit(reg_wr, reg_addr, PMAR_ADDR_MASK)) begin
            mask_d = reg_wdata[5:0];
        end
        summary_w = |(flags_q & ~mask_q);
        pin_d = status_pin_select_alarm ? summary_w : calibration_status;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flags_q <= PMAR_RST_FLAGS;
            mask_q <= PMAR_RST_MASK;
            link_en_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            mask_q <= mask_d;
            link_en_q <= link_en_d;
            pin_q <= pin_d;
        end
    end

    assign status_output_pin = pin_q;

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    // Unmapped addresses and flag and mask bits 7:6 read as zero; reserved flag bit 1 reads as stored
    always_comb begin
        unique case (reg_addr)
            PMAR_ADDR_MODE_B: reg_rdata = mode_b_q;
            PMAR_ADDR_MODE_C: reg_rdata = mode_c_q;
            PMAR_ADDR_MODE_D: reg_rdata = mode_d_q;
            PMAR_ADDR_SUMMARY: reg_rdata = {7'h00, summary_w};
            PMAR_ADDR_FLAGS: reg_rdata = {2'h0, flags_q};
            PMAR_ADDR_MASK: reg_rdata = {2'h0, mask_q};
            default: reg_rdata = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_fifo_flag_set: assert property (lane_fifo_error |=> flags_q[5])
        else $error("FIFO error did not set flag 5");
    chk_pll_flag_set: assert property (!serializer_pll_locked |=> flags_q[4])
        else $error("PLL unlock did not set flag 4");
    chk_realign_flag_set: assert property (sysref_realign |=> flags_q[2])
        else $error("Clock realignment did not set flag 2");
    chk_link_flag_set: assert property ((serial_link_enable && !link_mode_64b66b
            && !link_data_state) || (link_mode_64b66b && link_realign) |=> flags_q[3])
        else $error("Link condition did not set flag 3");
    chk_flag_w1c_clear: assert property (
            hit(reg_wr, reg_addr, PMAR_ADDR_FLAGS) && reg_wdata[5] && !lane_fifo_error
            |=> !flags_q[5])
        else $error("Writing one did not clear flag 5");
    chk_flag_stays_set: assert property (
            flags_q[5] && !hit(reg_wr, reg_addr, PMAR_ADDR_FLAGS) |=> flags_q[5])
        else $error("Flag 5 cleared without a write");
    chk_summary_read: assert property (
            reg_addr == PMAR_ADDR_SUMMARY |-> reg_rdata == {7'h00, |(flags_q & ~mask_q)})
        else $error("Summary read does not match flags and mask");
    chk_masked_all_quiet: assert property (mask_q == 6'h3F |-> !summary_w)
        else $error("Summary set while every source masked");
    chk_pin_route_alarm: assert property (
            status_pin_select_alarm |=> status_output_pin == $past(summary_w))
        else $error("Status pin does not follow summary");
    chk_mode_write_b: assert property (
            hit(reg_wr, reg_addr, PMAR_ADDR_MODE_B) |=> mode_b_q == $past(reg_wdata))
        else $error("Mode b write not stored");
    chk_mode_write_d: assert property (
            hit(reg_wr, reg_addr, PMAR_ADDR_MODE_D) |=> mode_d_q == $past(reg_wdata))
        else $error("Mode d write not stored");
    chk_pin_route_normal: assert property (
            !status_pin_select_alarm |=> status_output_pin == $past(calibration_status))
        else $error("Status pin does not follow calibration status");
    chk_unmasked_raises: assert property (flags_q[5] && !mask_q[5] |-> summary_w)
        else $error("Unmasked flag 5 did not raise the summary");
    chk_reset_values: assert property ($fell(reset) |-> mode_c_q == 8'h04
            && mode_d_q == 8'h1B && flags_q == 6'h3F && mask_q == 6'h3F)
        else $error("Wrong values after reset");

    cov_flag_cleared: cover property (flags_q[5] ##1 !flags_q[5]);
    cov_summary_rises: cover property (!summary_w ##1 summary_w);
    cov_low_power_b: cover property (mode_b_q == PMAR_CODE_B_LOW);
    cov_link_start_64b: cover property (link_mode_64b66b && serial_link_enable && !link_en_q);

endmodule

// ### verification/pmar_tb.sv
// Self-checking testbench for the power mode and alarm register slice
`timescale 1ns/1ps
module testbench;
    import pmar_pkg::*;
    logic clk, reset, port_sclk, port_sel_n, port_sdi, port_sdo, port_sdo_oe;
    logic serial_link_enable, link_data_state, link_mode_64b66b, link_realign;
    logic lane_fifo_error, serializer_pll_locked, sysref_realign, clock_divider_mismatch;
    logic status_pin_select_alarm, calibration_status, status_output_pin;
    logic [7:0] operating_point_code_b, operating_point_code_c, operating_point_code_d;
    logic [7:0] rd_val;
    logic [7:0] exp_q[$];
    logic [31:0] lfsr_q = 32'hB6334EF1;
    int mismatches = 0;
    int checks = 0;
    event rd_ev;

    pmar_regs dut (.clk(clk), .reset(reset), .port_sclk(port_sclk), .port_sel_n(port_sel_n),
        .port_sdi(port_sdi), .port_sdo(port_sdo), .port_sdo_oe(port_sdo_oe),
        .serial_link_enable(serial_link_enable), .link_data_state(link_data_state),
        .link_mode_64b66b(link_mode_64b66b), .link_realign(link_realign),
        .lane_fifo_error(lane_fifo_error), .serializer_pll_locked(serializer_pll_locked),
        .sysref_realign(sysref_realign), .clock_divider_mismatch(clock_divider_mismatch),
        .status_pin_select_alarm(status_pin_select_alarm),
        .calibration_status(calibration_status), .status_output_pin(status_output_pin),
        .operating_point_code_b(operating_point_code_b),
        .operating_point_code_c(operating_point_code_c),
        .operating_point_code_d(operating_point_code_d));

    // ------------------------------------------------------------
    // Clock, helpers and checks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Inputs always move 1 ns after the edge, so the design never races the bench
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        // A read whose byte never reached the monitor is a failure too
        if (exp_q.size() != 0) begin
            mismatches++;
        end
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // All alarm sources idle
    task automatic quiet();
        serial_link_enable = 1'b0;
        link_data_state = 1'b0;
        link_mode_64b66b = 1'b0;
        link_realign = 1'b0;
        lane_fifo_error = 1'b0;
        serializer_pll_locked = 1'b1;
        sysref_realign = 1'b0;
        clock_divider_mismatch = 1'b0;
    endtask

    // Each serial clock level is held 3 clk, above the 2 clk the port needs
    task automatic frame(input logic rw, input logic [14:0] a, input logic [7:0] wd,
                         output logic [7:0] rv);
        logic [23:0] bits;
        bits = {rw, a, wd};
        rv = 8'h00;
        port_sel_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            port_sdi = bits[i];
            port_sclk = 1'b0;
            tick(3);
            if (i < 8) rv[i] = port_sdo;
            if (i < 8) check8("data out enable", {7'h00, rw}, {7'h00, port_sdo_oe});
            port_sclk = 1'b1;
            tick(3);
        end
        port_sel_n = 1'b1;
        port_sclk = 1'b0;
        port_sdi = ~port_sdi;
        tick(4);
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] x;
        frame(1'b0, a, d, x);
    endtask

    // Read notes its expectation first; the monitor compares when the byte lands
    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        frame(1'b1, a, 8'h00, rd_val);
        -> rd_ev;
        check8("data out enable", 8'h00, {7'h00, port_sdo_oe});
    endtask

    task automatic fire(input int k);
        case (k)
            0: clock_divider_mismatch = 1'b1;
            2: sysref_realign = 1'b1;
            3: serial_link_enable = 1'b1;
            4: serializer_pll_locked = 1'b0;
            5: lane_fifo_error = 1'b1;
            6: begin
                link_mode_64b66b = 1'b1;
                link_realign = 1'b1;
            end
            7: begin
                link_mode_64b66b = 1'b1;
                serial_link_enable = 1'b1;
            end
            default: begin link_data_state = 1'b1; serial_link_enable = 1'b1; end
        endcase
        tick(1);
        quiet();
        tick(3);
    endtask

    task automatic do_reset();
        reset = 1'b1;
        tick(20);
        reset = 1'b0;
        tick(2);
    endtask

    // Monitor: takes the oldest expectation whenever a read completes
    initial begin
        forever begin
            @(rd_ev);
            check8("register read", exp_q.pop_front(), rd_val);
        end
    end

    // Watchdog sized well above the roughly 140 us that the tests need
    initial begin
        #500000;
        mismatches++;
        $display("watchdog expired");
        finish_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        static logic [7:0] lo[3] = '{PMAR_CODE_B_LOW, PMAR_CODE_C_LOW, PMAR_CODE_D_LOW};
        static logic [7:0] hi[3] = '{PMAR_CODE_B_HIGH, PMAR_CODE_C_HIGH, PMAR_CODE_D_HIGH};
        logic [7:0] val, cur, fl, m;
        logic lowp;
        port_sclk = 1'b0;
        port_sel_n = 1'b1;
        port_sdi = 1'b0;
        status_pin_select_alarm = 1'b0;
        calibration_status = 1'b0;
        quiet();
        do_reset();
        check8("code b", 8'h0F, operating_point_code_b);
        check8("code c", 8'h04, operating_point_code_c);
        check8("code d", 8'h1B, operating_point_code_d);
        rd(PMAR_ADDR_FLAGS, 8'h3F);
        rd(PMAR_ADDR_MASK, 8'h3F);
        rd(PMAR_ADDR_SUMMARY, 8'h00);
        rd(15'h0123, 8'h00);
        wr(PMAR_ADDR_FLAGS, 8'h00);
        rd(PMAR_ADDR_FLAGS, 8'h3F);
        wr(PMAR_ADDR_FLAGS, 8'h15);
        rd(PMAR_ADDR_FLAGS, 8'h2A);
        wr(PMAR_ADDR_FLAGS, 8'hFF);
        rd(PMAR_ADDR_FLAGS, 8'h00);
        $display("test reset_and_clear done");
        // Low, high, then a random pick: always a whole set of legal codes, link held off
        for (int v = 0; v < 3; v++) begin
            lfsr_q = lfsr_next(lfsr_q);
            lowp = (v == 0) || (v == 2 && lfsr_q[0]);
            for (int r = 0; r < 3; r++) begin
                val = lowp ? lo[r] : hi[r];
                wr(PMAR_ADDR_MODE_B + 15'(r), val);
                rd(PMAR_ADDR_MODE_B + 15'(r), val);
                cur = (r == 0) ? operating_point_code_b :
                      (r == 1) ? operating_point_code_c : operating_point_code_d;
                check8("mode code", val, cur);
            end
        end
        $display("test mode_registers done");
        for (int i = 0; i < 4; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            calibration_status = lfsr_q[0];
            tick(2);
            check8("status pin", {7'h00, lfsr_q[0]}, {7'h00, status_output_pin});
        end
        $display("test pin_normal done");
        // Each source alone, random mask on the others; case 8 must leave flags clear
        for (int k = 0; k < 9; k++) begin
            if (k != 1) begin
                fl = (k == 8) ? 8'h00 : 8'h01 << ((k > 5) ? 3 : k);
                lfsr_q = lfsr_next(lfsr_q);
                m = {2'b00, lfsr_q[5:0]} & ~fl;
                wr(PMAR_ADDR_MASK, m);
                rd(PMAR_ADDR_MASK, m);
                fire(k);
                rd(PMAR_ADDR_FLAGS, fl);
                rd(PMAR_ADDR_SUMMARY, {7'h00, fl != 8'h00});
                status_pin_select_alarm = 1'b1;
                tick(2);
                check8("alarm pin", {7'h00, fl != 8'h00}, {7'h00, status_output_pin});
                wr(PMAR_ADDR_MASK, 8'h3F);
                rd(PMAR_ADDR_SUMMARY, 8'h00);
                check8("masked pin", 8'h00, {7'h00, status_output_pin});
                wr(PMAR_ADDR_FLAGS, fl);
                rd(PMAR_ADDR_FLAGS, 8'h00);
                status_pin_select_alarm = 1'b0;
            end
        end
        $display("test alarm_sources done");
        do_reset();
        rd(PMAR_ADDR_FLAGS, 8'h3F);
        rd(PMAR_ADDR_MODE_B, 8'h0F);
        check8("code d", 8'h1B, operating_point_code_d);
        $display("test second_reset done");
        // Let the monitor take the last read before the verdict
        tick(1);
        finish_test();
    end
endmodule
